// File: design/shalu_defines.svh
// Purpose: Constants for the signed halving SIMD datapath
// Assumes: 32-bit register file with 16 architectural registers
// Notes:   Definitions only
`ifndef SHALU_DEFINES_SVH
`define SHALU_DEFINES_SVH

// -----------------------------------------------------------------
// Widths and lane positions
// -----------------------------------------------------------------
`define SHALU_WORD_W 32
`define SHALU_HALF_W 16
`define SHALU_BYTE_W 8
`define SHALU_IDX_W 4
`define SHALU_HI_MSB 31
`define SHALU_HI_LSB 16
`define SHALU_LO_MSB 15
`define SHALU_LO_LSB 0

// -----------------------------------------------------------------
// Reserved register indices and reset values
// -----------------------------------------------------------------
`define SHALU_STACK_POINTER_IDX 4'hd
`define SHALU_PROGRAM_COUNTER_IDX 4'hf
`define SHALU_RESULT_RST 32'h0000_0000
`define SHALU_IDX_RST 4'h0

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SHALU_LATENCY 1

`endif

// File: design/shalu_pkg.sv
// Purpose: Types for the signed halving SIMD datapath
// Assumes: Nothing beyond the defines header
// Notes:   Operation codes carry no fixed encoding
package shalu_pkg;

   // ----------------------------------------------------------------
   // Operation selector
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      OP_HALVING_ADD_HALFWORD_PAIR,
      OP_HALVING_ADD_BYTE_QUAD,
      OP_HALVING_ADD_SUB_EXCHANGE,
      OP_HALVING_SUB_ADD_EXCHANGE,
      OP_HALVING_SUB_HALFWORD_PAIR,
      OP_HALVING_SUB_BYTE_QUAD
   } shalu_op_t;

endpackage : shalu_pkg

// File: design/shalu_lane.sv
// Purpose: One halfword slice of the halving datapath
// Assumes: Operands already routed for exchange operations
// Notes:   Purely combinational; splits into two byte lanes on request
`timescale 1ns/10ps
`default_nettype none
`include "shalu_defines.svh"

module shalu_lane
(
   input wire logic [15:0] a_i,   // First operand slice
   input wire logic [15:0] b_i,   // Second operand slice
   input wire logic sub_i,        // High to subtract b from a
   input wire logic byte_i,       // High for two independent byte lanes
   output logic [15:0] res_o      // Halved slice result
);

   // ----------------------------------------------------------------
   // Halving helpers
   // ----------------------------------------------------------------
   // One extra bit keeps the sum exact, so the shift never overflows
   function automatic logic [15:0] halve16(input logic [15:0] a, input logic [15:0] b,
                                           input logic sub);
      logic signed [16:0] ext;
      ext = sub ? ($signed({a[15], a}) - $signed({b[15], b}))
                : ($signed({a[15], a}) + $signed({b[15], b}));
      halve16 = 16'(ext >>> 1);
   endfunction : halve16

   // Same for one byte lane
   function automatic logic [7:0] halve8(input logic [7:0] a, input logic [7:0] b,
                                         input logic sub);
      logic signed [8:0] ext;
      ext = sub ? ($signed({a[7], a}) - $signed({b[7], b}))
                : ($signed({a[7], a}) + $signed({b[7], b}));
      halve8 = 8'(ext >>> 1);
   endfunction : halve8

   // ----------------------------------------------------------------
   // Lane results
   // ----------------------------------------------------------------
   wire logic [15:0] half_res;  // Whole halfword lane
   wire logic [15:0] byte_res;  // Two byte lanes side by side

   assign half_res = halve16(a_i, b_i, sub_i);  // see RULE13 see RULE3
   assign byte_res = {halve8(a_i[15:8], b_i[15:8], sub_i),
                      halve8(a_i[7:0], b_i[7:0], sub_i)};  // see RULE13 see RULE3
   assign res_o = byte_i ? byte_res : half_res;

endmodule : shalu_lane
`default_nettype wire

// File: design/shalu_alu.sv
// Purpose: Signed halving add/subtract SIMD datapath, one register stage
// Assumes: Issue logic presents operands, indices and condition in one cycle
// Notes:   Result and write-back controls appear one cycle after issue
//
// Contract
// RULE1 - Halfword pairs added, halved, both written
// RULE2 - Four byte lanes added, halved, written
// RULE3 - Halve by one-bit right shift
// RULE4 - Exchange add-sub: top gets halved hi plus lo
// RULE5 - Exchange add-sub: bottom gets halved lo minus hi
// RULE6 - Exchange sub-add: top gets halved hi minus lo
// RULE7 - Exchange sub-add: bottom gets halved lo plus hi
// RULE8 - Halfword pairs subtracted, halved, both written
// RULE9 - Four byte lanes subtracted, halved, written
// RULE10 - Condition and lane flags never modified
// RULE11 - Missing destination means first source
// RULE12 - Issuer never names stack or program counter
// RULE13 - Extra sign bit, arithmetic shift, no overflow
// RULE14 - Failed condition leaves destination unchanged
`timescale 1ns/10ps
`default_nettype none
`include "shalu_defines.svh"

module shalu_alu
(
   input wire logic clock_i,                         // Core clock, 200 MHz
   input wire logic resetn_i,                        // Synchronous reset, active low
   input wire logic issue_valid_i,                   // Operation issued this cycle
   input wire shalu_pkg::shalu_op_t op_i,            // Which halving operation
   input wire logic cond_pass_i,                     // Condition qualifier holds
   input wire logic [31:0] first_src_i,              // first_src_reg value
   input wire logic [31:0] second_src_i,             // second_src_reg value
   input wire logic [3:0] first_src_idx_i,           // first_src_reg index
   input wire logic [3:0] second_src_idx_i,          // second_src_reg index
   input wire logic dest_given_i,                    // Destination named explicitly
   input wire logic [3:0] dest_idx_i,                // Destination index when given
   output logic [31:0] result_o,                     // Halved result
   output logic wr_en_o,                             // Write result to wr_idx_o
   output logic [3:0] wr_idx_o,                      // Destination to write
   output logic illegal_o,                           // Reserved register was named
   output logic flags_we_o,                          // Condition flag write, always low
   output logic ge_we_o                              // Lane flag write, always low
);

   // ----------------------------------------------------------------
   // Operation decode
   // ----------------------------------------------------------------
   wire logic op_byte;   // Byte-lane operation
   wire logic op_exch;   // Exchange operation, swaps second source halves
   wire logic sub_hi;    // Upper lane subtracts
   wire logic sub_lo;    // Lower lane subtracts

   assign op_byte = (op_i == shalu_pkg::OP_HALVING_ADD_BYTE_QUAD) ||
                    (op_i == shalu_pkg::OP_HALVING_SUB_BYTE_QUAD);
   assign op_exch = (op_i == shalu_pkg::OP_HALVING_ADD_SUB_EXCHANGE) ||
                    (op_i == shalu_pkg::OP_HALVING_SUB_ADD_EXCHANGE);
   // Add-sub exchange adds on top; sub-add exchange subtracts on top
   assign sub_hi = (op_i == shalu_pkg::OP_HALVING_SUB_HALFWORD_PAIR) ||
                   (op_i == shalu_pkg::OP_HALVING_SUB_BYTE_QUAD) ||
                   (op_i == shalu_pkg::OP_HALVING_SUB_ADD_EXCHANGE);  // see RULE4 see RULE6
   assign sub_lo = (op_i == shalu_pkg::OP_HALVING_SUB_HALFWORD_PAIR) ||
                   (op_i == shalu_pkg::OP_HALVING_SUB_BYTE_QUAD) ||
                   (op_i == shalu_pkg::OP_HALVING_ADD_SUB_EXCHANGE);  // see RULE5 see RULE7

   // ----------------------------------------------------------------
   // Operand routing
   // ----------------------------------------------------------------
   wire logic [15:0] b_for_hi;  // Second operand slice seen by upper lane
   wire logic [15:0] b_for_lo;  // Second operand slice seen by lower lane
   wire logic [31:0] lane_res;  // Both lanes joined

   // Exchange pairs the top of one source with the bottom of the other
   assign b_for_hi = op_exch ? second_src_i[`SHALU_LO_MSB:`SHALU_LO_LSB]
                             : second_src_i[`SHALU_HI_MSB:`SHALU_HI_LSB];  // see RULE4 see RULE6
   assign b_for_lo = op_exch ? second_src_i[`SHALU_HI_MSB:`SHALU_HI_LSB]
                             : second_src_i[`SHALU_LO_MSB:`SHALU_LO_LSB];  // see RULE5 see RULE7

   // Upper halfword or bytes 3 and 2
   shalu_lane u_lane_hi
   (
      .a_i(first_src_i[`SHALU_HI_MSB:`SHALU_HI_LSB]),
      .b_i(b_for_hi),
      .sub_i(sub_hi),
      .byte_i(op_byte),
      .res_o(lane_res[`SHALU_HI_MSB:`SHALU_HI_LSB])
   );  // see RULE1 see RULE2 see RULE8 see RULE9

   // Lower halfword or bytes 1 and 0
   shalu_lane u_lane_lo
   (
      .a_i(first_src_i[`SHALU_LO_MSB:`SHALU_LO_LSB]),
      .b_i(b_for_lo),
      .sub_i(sub_lo),
      .byte_i(op_byte),
      .res_o(lane_res[`SHALU_LO_MSB:`SHALU_LO_LSB])
   );  // see RULE1 see RULE2 see RULE8 see RULE9

   // ----------------------------------------------------------------
   // Destination and write qualification
   // ----------------------------------------------------------------
   wire logic [3:0] dest_idx;  // Effective destination
   wire logic reserved_hit;    // Some index names a reserved register
   wire logic do_write;        // Write back this operation
   wire logic do_reject;       // Drop this operation as illegal

   function automatic logic is_reserved(input logic [3:0] idx);
      is_reserved = (idx == `SHALU_STACK_POINTER_IDX) ||
                    (idx == `SHALU_PROGRAM_COUNTER_IDX);
   endfunction : is_reserved

   assign dest_idx = dest_given_i ? dest_idx_i : first_src_idx_i;  // see RULE11
   // Issuer should never do this; dropping the write keeps state safe if it does
   assign reserved_hit = is_reserved(dest_idx) || is_reserved(first_src_idx_i) ||
                         is_reserved(second_src_idx_i);  // see RULE12
   assign do_write = issue_valid_i && cond_pass_i && !reserved_hit;  // see RULE14
   assign do_reject = issue_valid_i && cond_pass_i && reserved_hit;

   // ----------------------------------------------------------------
   // Result stage
   // ----------------------------------------------------------------
   logic [31:0] result_ff;  // Last written result
   logic wr_en_ff;          // Write strobe, one cycle
   logic [3:0] wr_idx_ff;   // Write index
   logic illegal_ff;        // Reject pulse, one cycle

   // Result only loads on a real write so a skipped op leaves it alone
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         result_ff <= `SHALU_RESULT_RST;
         wr_idx_ff <= `SHALU_IDX_RST;
      end
      else if (do_write)
      begin
         result_ff <= lane_res;
         wr_idx_ff <= dest_idx;
      end
   end

   // Strobes
   always_ff @(posedge clock_i)
   begin
      if (!resetn_i)
      begin
         wr_en_ff <= 1'b0;
         illegal_ff <= 1'b0;
      end
      else
      begin
         wr_en_ff <= do_write;  // see RULE14
         illegal_ff <= do_reject;
      end
   end

   assign result_o = result_ff;
   assign wr_en_o = wr_en_ff;
   assign wr_idx_o = wr_idx_ff;
   assign illegal_o = illegal_ff;
   // No halving operation ever writes flags
   assign flags_we_o = 1'b0;  // see RULE10
   assign ge_we_o = 1'b0;     // see RULE10

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   // Independent model: take the top bits of the widened sum, not a shift
   function automatic logic [15:0] ref16(input logic [15:0] a, input logic [15:0] b,
                                         input logic sub);
      logic [16:0] t;
      t = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
      ref16 = t[16:1];
   endfunction : ref16

   function automatic logic [7:0] ref8(input logic [7:0] a, input logic [7:0] b,
                                       input logic sub);
      logic [8:0] t;
      t = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
      ref8 = t[8:1];
   endfunction : ref8

   wire logic [31:0] a;   // Short alias
   wire logic [31:0] b;   // Short alias
   wire logic go;         // Issued and written
   assign a = first_src_i;
   assign b = second_src_i;
   assign go = do_write;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   halfword_add_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE1
      go && op_i == shalu_pkg::OP_HALVING_ADD_HALFWORD_PAIR |=> result_o ==
      {ref16($past(a[31:16]), $past(b[31:16]), 1'b0), ref16($past(a[15:0]), $past(b[15:0]), 1'b0)})
      else $error("Halfword halving add wrong");

   byte_add_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE2
      go && op_i == shalu_pkg::OP_HALVING_ADD_BYTE_QUAD |=> result_o ==
      {ref8($past(a[31:24]), $past(b[31:24]), 1'b0), ref8($past(a[23:16]), $past(b[23:16]), 1'b0),
       ref8($past(a[15:8]), $past(b[15:8]), 1'b0), ref8($past(a[7:0]), $past(b[7:0]), 1'b0)})
      else $error("Byte halving add wrong");

   sign_kept_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE13 see RULE3
      go && op_i == shalu_pkg::OP_HALVING_SUB_HALFWORD_PAIR && a[31] != b[31] |=>
      result_o[31] == $past(a[31]))
      else $error("Halved difference lost its sign");

   add_sub_top_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE4
      go && op_i == shalu_pkg::OP_HALVING_ADD_SUB_EXCHANGE |=>
      result_o[31:16] == ref16($past(a[31:16]), $past(b[15:0]), 1'b0))
      else $error("Add-sub exchange top lane wrong");

   add_sub_bottom_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE5
      go && op_i == shalu_pkg::OP_HALVING_ADD_SUB_EXCHANGE |=>
      result_o[15:0] == ref16($past(a[15:0]), $past(b[31:16]), 1'b1))
      else $error("Add-sub exchange bottom lane wrong");

   sub_add_top_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE6
      go && op_i == shalu_pkg::OP_HALVING_SUB_ADD_EXCHANGE |=>
      result_o[31:16] == ref16($past(a[31:16]), $past(b[15:0]), 1'b1))
      else $error("Sub-add exchange top lane wrong");

   sub_add_bottom_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE7
      go && op_i == shalu_pkg::OP_HALVING_SUB_ADD_EXCHANGE |=>
      result_o[15:0] == ref16($past(a[15:0]), $past(b[31:16]), 1'b0))
      else $error("Sub-add exchange bottom lane wrong");

   halfword_sub_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE8
      go && op_i == shalu_pkg::OP_HALVING_SUB_HALFWORD_PAIR |=> result_o ==
      {ref16($past(a[31:16]), $past(b[31:16]), 1'b1), ref16($past(a[15:0]), $past(b[15:0]), 1'b1)})
      else $error("Halfword halving subtract wrong");

   byte_sub_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE9
      go && op_i == shalu_pkg::OP_HALVING_SUB_BYTE_QUAD |=> result_o ==
      {ref8($past(a[31:24]), $past(b[31:24]), 1'b1), ref8($past(a[23:16]), $past(b[23:16]), 1'b1),
       ref8($past(a[15:8]), $past(b[15:8]), 1'b1), ref8($past(a[7:0]), $past(b[7:0]), 1'b1)})
      else $error("Byte halving subtract wrong");

   flags_quiet_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE10
      issue_valid_i |-> !flags_we_o && !ge_we_o ##1 !flags_we_o && !ge_we_o)
      else $error("Flag write seen around a halving op");

   default_dest_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE11
      go && !dest_given_i |=> wr_en_o && wr_idx_o == $past(first_src_idx_i))
      else $error("Default destination is not the first source");

   reserved_drop_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE12
      issue_valid_i && cond_pass_i && reserved_hit |=> illegal_o && !wr_en_o
      && $stable(result_o))
      else $error("Reserved register not rejected");

   cond_skip_a : assert property (@(posedge clock_i) disable iff (!resetn_i) // see RULE14
      issue_valid_i && !cond_pass_i |=> !wr_en_o && $stable(result_o) && $stable(wr_idx_o))
      else $error("Failed condition still wrote");

endmodule : shalu_alu
`default_nettype wire

// File: dv/shalu_issue_model.sv
// Purpose: Register file of the issuing pipeline, facing the halving datapath
// Assumes: Operands are read combinationally from the indices on the issue bus
// Notes:   The bench preloads entries by reference; write-back lands on wr_en_i
`timescale 1ns/10ps
`default_nettype none

module shalu_issue_model
(
   input wire logic clock_i,             // Core clock
   input wire logic [3:0] first_src_idx_i,   // Index of first source
   input wire logic [3:0] second_src_idx_i,  // Index of second source
   input wire logic wr_en_i,             // Write-back strobe from the datapath
   input wire logic [3:0] wr_idx_i,      // Write-back index
   input wire logic [31:0] result_i,     // Write-back value
   output logic [31:0] first_src_o,      // First operand value
   output logic [31:0] second_src_o      // Second operand value
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [31:0] regs [16];  // Plain array so the bench may preload it

   // Operand read; reserved indices only reach here when a test asks
   assign first_src_o = regs[first_src_idx_i];
   assign second_src_o = regs[second_src_idx_i];

   // Write-back of every accepted result
   always @(posedge clock_i)
   begin
      if (wr_en_i === 1'b1)
      begin
         regs[wr_idx_i] <= result_i;
      end
   end
endmodule : shalu_issue_model

`default_nettype wire

// File: dv/signed_halving_simd_alu_test.sv
// Purpose: Self-checking bench for the signed halving SIMD datapath
// Assumes: One-cycle latency and refusal behaviour as handed over
// Notes:   Expected lanes are rebuilt here from 17/9-bit sums
`timescale 1ns/10ps
`default_nettype none

module signed_halving_simd_alu_test;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clock_i = 1'b0;                 // Core clock
   logic resetn_i = 1'b0;                // Reset, active low
   logic issue_valid_i = 1'b0;           // Issue strobe
   shalu_pkg::shalu_op_t op_i = shalu_pkg::OP_HALVING_ADD_HALFWORD_PAIR;
   logic cond_pass_i = 1'b0;             // Condition qualifier
   logic [3:0] first_src_idx_i = 4'h1;   // First source index
   logic [3:0] second_src_idx_i = 4'h2;  // Second source index
   logic dest_given_i = 1'b0;            // Destination named
   logic [3:0] dest_idx_i = 4'h0;        // Destination index
   logic [31:0] first_src_i, second_src_i, result_o;
   logic wr_en_o, illegal_o, flags_we_o, ge_we_o;
   logic [3:0] wr_idx_o;
   int miscompares = 0;                  // Mismatch counter
   int cmp_count = 0;                    // Comparison counter
   logic [31:0] last_exp = 32'h0000_0000;  // Last value expected on result_o
   logic [31:0] va [2] = '{32'h7fff_8000, 32'h8001_7f80};  // Extreme lanes
   logic [31:0] vb [2] = '{32'h7fff_8000, 32'h7fff_80ff};

   // ----------------------------------------------------------------
   // Design and partner
   // ----------------------------------------------------------------
   shalu_alu uut (.clock_i(clock_i), .resetn_i(resetn_i), .issue_valid_i(issue_valid_i),
      .op_i(op_i), .cond_pass_i(cond_pass_i), .first_src_i(first_src_i),
      .second_src_i(second_src_i), .first_src_idx_i(first_src_idx_i),
      .second_src_idx_i(second_src_idx_i), .dest_given_i(dest_given_i),
      .dest_idx_i(dest_idx_i), .result_o(result_o), .wr_en_o(wr_en_o),
      .wr_idx_o(wr_idx_o), .illegal_o(illegal_o), .flags_we_o(flags_we_o),
      .ge_we_o(ge_we_o));
   shalu_issue_model model (.clock_i(clock_i), .first_src_idx_i(first_src_idx_i),
      .second_src_idx_i(second_src_idx_i), .wr_en_i(wr_en_o), .wr_idx_i(wr_idx_o),
      .result_i(result_o), .first_src_o(first_src_i), .second_src_o(second_src_i));

   // Clock, 5 ns period
   initial
   begin
      forever #2.5 clock_i = ~clock_i;
   end

   // ----------------------------------------------------------------
   // Reference arithmetic, one extra sign bit then drop the lsb
   // ----------------------------------------------------------------
   function automatic logic [15:0] hh(input logic [15:0] x, input logic [15:0] y,
                                      input logic s);
      logic [16:0] t;
      t = s ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
      return t[16:1];
   endfunction : hh

   function automatic logic [7:0] bb(input logic [7:0] x, input logic [7:0] y, input logic s);
      logic [8:0] t;
      t = s ? {x[7], x} - {y[7], y} : {x[7], x} + {y[7], y};
      return t[8:1];
   endfunction : bb

   function automatic logic [31:0] ref_val(input shalu_pkg::shalu_op_t op,
                                           input logic [31:0] a, input logic [31:0] b);
      logic s;
      s = (op == shalu_pkg::OP_HALVING_SUB_HALFWORD_PAIR)
          || (op == shalu_pkg::OP_HALVING_SUB_BYTE_QUAD);
      case (op)
         shalu_pkg::OP_HALVING_ADD_SUB_EXCHANGE:
            return {hh(a[31:16], b[15:0], 1'b0), hh(a[15:0], b[31:16], 1'b1)};
         shalu_pkg::OP_HALVING_SUB_ADD_EXCHANGE:
            return {hh(a[31:16], b[15:0], 1'b1), hh(a[15:0], b[31:16], 1'b0)};
         shalu_pkg::OP_HALVING_ADD_BYTE_QUAD, shalu_pkg::OP_HALVING_SUB_BYTE_QUAD:
            return {bb(a[31:24], b[31:24], s), bb(a[23:16], b[23:16], s),
                    bb(a[15:8], b[15:8], s), bb(a[7:0], b[7:0], s)};
         default:
            return {hh(a[31:16], b[31:16], s), hh(a[15:0], b[15:0], s)};
      endcase
   endfunction : ref_val

   // ----------------------------------------------------------------
   // Drivers and comparison
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Present one issue at the next edge
   task automatic send(input shalu_pkg::shalu_op_t op, input logic [3:0] fi,
                       input logic [3:0] si, input logic dg, input logic [3:0] di,
                       input logic cp);
      @(posedge clock_i);
      issue_valid_i <= 1'b1;
      op_i <= op;
      first_src_idx_i <= fi;
      second_src_idx_i <= si;
      dest_given_i <= dg;
      dest_idx_i <= di;
      cond_pass_i <= cp;
   endtask : send

   // Drop the strobe at the taking edge, then let outputs settle
   task automatic idle();
      @(posedge clock_i);
      issue_valid_i <= 1'b0;
      #1;
   endtask : idle

   // Look at a write pulse in the cycle it stands
   task automatic expect_write(input logic [31:0] res, input logic [3:0] idx);
      chk("wr_en", {31'h0, wr_en_o}, 32'h1);
      chk("illegal", {31'h0, illegal_o}, 32'h0);
      chk("result", result_o, res);
      chk("wr_idx", {28'h0, wr_idx_o}, {28'h0, idx});
      chk("flag writes", {30'h0, ge_we_o, flags_we_o}, 32'h0);
      last_exp = res;
   endtask : expect_write

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      chk("reset result", result_o, 32'h0);
      chk("reset pulses", {28'h0, wr_en_o, illegal_o, flags_we_o, ge_we_o}, 32'h0);
   endtask : t_reset_values

   // Every operation on saturating lane patterns, written to index 3
   task automatic t_all_ops();
      shalu_pkg::shalu_op_t op;
      for (int i = 0; i < 6; i++)
      begin
         for (int k = 0; k < 2; k++)
         begin
            op = shalu_pkg::shalu_op_t'(i);
            model.regs[1] = va[k];
            model.regs[2] = vb[k];
            send(op, 4'h1, 4'h2, 1'b1, 4'h3, 1'b1);
            idle();
            expect_write(ref_val(op, va[k], vb[k]), 4'h3);
            @(posedge clock_i);
            #1;
            chk("write-back", model.regs[3], ref_val(op, va[k], vb[k]));
         end
      end
   endtask : t_all_ops

   // Two issues on consecutive edges, no gap
   task automatic t_back_to_back();
      model.regs[5] = 32'h1234_fedc;
      model.regs[6] = 32'h8000_0101;
      send(shalu_pkg::OP_HALVING_SUB_BYTE_QUAD, 4'h5, 4'h6, 1'b1, 4'h7, 1'b1);
      send(shalu_pkg::OP_HALVING_ADD_SUB_EXCHANGE, 4'h6, 4'h5, 1'b1, 4'h8, 1'b1);
      #1;
      expect_write(32'h491a_feed, 4'h7);
      idle();
      expect_write(32'hbf6e_f766, 4'h8);
   endtask : t_back_to_back

   // Failed condition must leave the last result standing
   task automatic t_cond_fail();
      send(shalu_pkg::OP_HALVING_ADD_HALFWORD_PAIR, 4'h5, 4'h6, 1'b1, 4'h9, 1'b0);
      idle();
      chk("cond wr_en", {31'h0, wr_en_o}, 32'h0);
      chk("cond result", result_o, last_exp);
      chk("cond wr_idx", {28'h0, wr_idx_o}, 32'h8);
   endtask : t_cond_fail

   // No destination named: first source is written
   task automatic t_default_dest();
      send(shalu_pkg::OP_HALVING_SUB_HALFWORD_PAIR, 4'h6, 4'h5, 1'b0, 4'h9, 1'b1);
      idle();
      expect_write(32'hb6e6_0112, 4'h6);
   endtask : t_default_dest

   // Reserved index in each position: pulse for one cycle, no write
   task automatic t_reserved();
      logic [3:0] f [3] = '{4'hd, 4'h1, 4'h1};
      logic [3:0] s [3] = '{4'h2, 4'hf, 4'h2};
      logic [3:0] d [3] = '{4'h3, 4'h3, 4'hd};
      for (int i = 0; i < 3; i++)
      begin
         send(shalu_pkg::OP_HALVING_ADD_BYTE_QUAD, f[i], s[i], 1'b1, d[i], 1'b1);
         idle();
         chk("reserved pulse", {30'h0, illegal_o, wr_en_o}, 32'h2);
         @(posedge clock_i);
         #1;
         chk("reserved after", {30'h0, illegal_o, wr_en_o}, 32'h0);
      end
   endtask : t_reserved

   // ----------------------------------------------------------------
   // Closing, sequence and watchdog
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (6) @(posedge clock_i);
      resetn_i <= 1'b1;
      #1;
      t_reset_values();
      t_all_ops();
      t_back_to_back();
      t_cond_fail();
      t_default_dest();
      t_reserved();
      wrap_up();
   end

   // Whole run is about 60 cycles; cut a hang well past that
   initial
   begin
      #20000;
      miscompares++;
      wrap_up();
   end
endmodule : signed_halving_simd_alu_test

`default_nettype wire
